// ### rcmd_cfg.svh
// Constants for the reset clock mode decoder: offsets, fields, reset values, factor codes
`ifndef RCMD_CFG_SVH
`define RCMD_CFG_SVH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define RCMD_OFS_CTRL        12'h000
`define RCMD_OFS_STATUS      12'h004
`define RCMD_OFS_FACTORS     12'h008
`define RCMD_OFS_PENDING     12'h00C

// -----------------------------------------------------------------------------
// Control register fields and reset value
// -----------------------------------------------------------------------------
`define RCMD_CTRL_EXT_EN     0
`define RCMD_CTRL_RESET      8'h01

// -----------------------------------------------------------------------------
// Status register fields
// -----------------------------------------------------------------------------
`define RCMD_ST_CODE_LSB     0
`define RCMD_ST_EXT          8
`define RCMD_ST_UNSUP        9
`define RCMD_ST_ARMED        10
`define RCMD_ST_HARD_RESET_IN       11

// -----------------------------------------------------------------------------
// Factor register fields
// -----------------------------------------------------------------------------
`define RCMD_FA_CPM_LSB      0
`define RCMD_FA_CPM_FRAC     7
`define RCMD_FA_CORE_LSB     8
`define RCMD_FA_CORE_FRAC    15

// -----------------------------------------------------------------------------
// Factors in half units (2.5 -> 5), basic strap modes
// -----------------------------------------------------------------------------
`define RCMD_B0_CPM          5'h06
`define RCMD_B0_CORE         5'h08
`define RCMD_B1_CPM          5'h06
`define RCMD_B1_CORE         5'h0A
`define RCMD_B2_CPM          5'h08
`define RCMD_B2_CORE         5'h08
`define RCMD_B3_CPM          5'h08
`define RCMD_B3_CORE         5'h0A
`define RCMD_B4_CPM          5'h04
`define RCMD_B4_CORE         5'h05
`define RCMD_B5_CPM          5'h04
`define RCMD_B5_CORE         5'h06
`define RCMD_B6_CPM          5'h05
`define RCMD_B6_CORE         5'h05
`define RCMD_B7_CPM          5'h05
`define RCMD_B7_CORE         5'h06

// -----------------------------------------------------------------------------
// Extended mode table: codes FIRST..LAST, groups of GROUP core steps
// -----------------------------------------------------------------------------
`define RCMD_EXT_FIRST       7'h08
`define RCMD_EXT_LAST        7'h20
`define RCMD_EXT_GROUP       5'h05
`define RCMD_EXT_CPM_BASE    5'h02
`define RCMD_EXT_CORE_BASE   5'h04

// -----------------------------------------------------------------------------
// Bus responses
// -----------------------------------------------------------------------------
`define RCMD_RESP_OKAY       2'h0
`define RCMD_RESP_SLVERR     2'h2

`endif

// ### rcmd_pkg.sv
// Types shared by the reset clock mode decoder
package rcmd_pkg;

   // -----------------------------------------------------------------------------
   // Configuration capture sequence
   // -----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      RCMD_RUN     = 3'h1,   // Normal running, configuration applied
      RCMD_SAMPLE  = 3'h2,   // Hard reset held, pins being sampled
      RCMD_APPLY   = 3'h4    // Hard reset released, decide on applying
   } rcmd_state_type;

   // Decoded factors in half units plus unsupported code flag
   typedef struct packed {
      logic [4:0] cpm_half;
      logic [4:0] core_half;
      logic       unsupported;
   } rcmd_factor_type;

endpackage

// ### rcmd_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none

module rcmd_sync #(
   parameter int            WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] meta_q;   // First stage, read only by the second

   // -----------------------------------------------------------------------------
   // Two stages, reset to the idle level of the pins
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q    <= RESET_VAL;
         level_out <= RESET_VAL;
      end else if (clk_en) begin
         meta_q    <= pin_in;
         level_out <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ### rcmd_top.sv
// Reset clock mode decoder: strap capture, mode decode and AXI4-Lite status
//
// Behaviour
// - Sample mode straps while hard reset asserted
// - Codes 000/001: comm x3, core x4/x5
// - Codes 010/011: comm x4, core x4/x5
// - Codes 100/101: comm x2, core x2.5/x3
// - Codes 110/111: comm x2.5, core x2.5/x3
// - Config select adds four upper mode bits
// - New configuration applies only after power-on reset or aresetn
// - Extended code: upper four, lower three bits
`timescale 1ns/100ps
`default_nettype none
`include "rcmd_cfg.svh"

module rcmd_top
   import rcmd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   // Pins sampled at hard reset
   input  wire logic        hard_reset_in_n,
   input  wire logic        power_on_reset_n,
   input  wire logic        reset_config_select_n,
   input  wire logic [2:0]  clock_mode_straps,
   input  wire logic [3:0]  extended_mode_upper_bits,
   // Decoded PLL settings
   output logic      [4:0]  cpm_mult_half,
   output logic             cpm_mult_frac,
   output logic      [4:0]  core_mult_half,
   output logic             core_mult_frac,
   output logic      [6:0]  applied_mode_code,
   output logic             applied_mode_ext,
   // AXI4-Lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // -----------------------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------------------
   logic [2:0]      straps_s;          // Synchronised strap levels
   logic [3:0]      upper_s;           // Synchronised configuration word bits
   logic [2:0]      ctl_s;             // Synchronised hard reset, por, config select
   logic            hard_reset_in_act;        // Hard reset asserted
   logic            por_act;           // Power-on reset asserted
   logic            cfgsel_act;        // Configuration word requested
   rcmd_state_type  state_q;           // Capture sequence state
   rcmd_state_type  state_d;
   logic [6:0]      pend_code_q;       // Code sampled during last hard reset
   logic            pend_ext_q;        // Sampled code is extended
   logic            armed_q;           // Power-on reset seen since last apply
   logic [7:0]      ctrl_q;            // Software control byte
   rcmd_factor_type dec;               // Decode of the pending code
   logic            aw_full_q;         // Write address held
   logic            w_full_q;          // Write data held
   logic [11:0]     aw_addr_q;
   logic [31:0]     w_data_q;
   logic [3:0]      w_strb_q;
   logic            aw_hs;
   logic            w_hs;
   logic            wr_commit;
   logic            ar_hs;
   logic [31:0]     rd_word;
   logic [1:0]      rd_resp;

   assign hard_reset_in_act = ~ctl_s[0];
   assign por_act    = ~ctl_s[1];
   assign cfgsel_act = ~ctl_s[2];

   // -----------------------------------------------------------------------------
   // Pin synchronisers (pins idle high for the active-low controls)
   // -----------------------------------------------------------------------------
   rcmd_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync_ctl (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clk_en    (clk_en),
      .pin_in    ({reset_config_select_n, power_on_reset_n, hard_reset_in_n}),
      .level_out (ctl_s)
   );

   rcmd_sync #(.WIDTH(7), .RESET_VAL(7'h00)) u_sync_mode (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clk_en    (clk_en),
      .pin_in    ({extended_mode_upper_bits, clock_mode_straps}),
      .level_out ({upper_s, straps_s})
   );

   // -----------------------------------------------------------------------------
   // Mode decode, factors in half units so 2.5 is its own code
   // -----------------------------------------------------------------------------
   always_comb begin
      logic [6:0] idx;
      idx             = 7'h00;
      dec.unsupported = 1'b0;
      dec.cpm_half    = `RCMD_B0_CPM;
      dec.core_half   = `RCMD_B0_CORE;
      if (pend_ext_q && pend_code_q >= `RCMD_EXT_FIRST && pend_code_q <= `RCMD_EXT_LAST) begin
         // Extended modes step core 4..8 inside each comm group
         idx           = pend_code_q - `RCMD_EXT_FIRST;
         dec.cpm_half  = 5'((`RCMD_EXT_CPM_BASE + 5'(idx[4:0] / `RCMD_EXT_GROUP)) << 1);
         dec.core_half = 5'((`RCMD_EXT_CORE_BASE + 5'(idx[4:0] % `RCMD_EXT_GROUP)) << 1);
      end else begin
         // Outside the extended table fall back to the strap bits and flag it
         dec.unsupported = pend_ext_q;
         unique case (pend_code_q[2:0])
            3'h0: begin
               dec.cpm_half  = `RCMD_B0_CPM;
               dec.core_half = `RCMD_B0_CORE;
            end
            3'h1: begin
               dec.cpm_half  = `RCMD_B1_CPM;
               dec.core_half = `RCMD_B1_CORE;
            end
            3'h2: begin
               dec.cpm_half  = `RCMD_B2_CPM;
               dec.core_half = `RCMD_B2_CORE;
            end
            3'h3: begin
               dec.cpm_half  = `RCMD_B3_CPM;
               dec.core_half = `RCMD_B3_CORE;
            end
            3'h4: begin
               dec.cpm_half  = `RCMD_B4_CPM;
               dec.core_half = `RCMD_B4_CORE;
            end
            3'h5: begin
               dec.cpm_half  = `RCMD_B5_CPM;
               dec.core_half = `RCMD_B5_CORE;
            end
            3'h6: begin
               dec.cpm_half  = `RCMD_B6_CPM;
               dec.core_half = `RCMD_B6_CORE;
            end
            3'h7: begin
               dec.cpm_half  = `RCMD_B7_CPM;
               dec.core_half = `RCMD_B7_CORE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------------------
   // Capture sequence next state
   // -----------------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RCMD_RUN:    if (hard_reset_in_act) state_d = RCMD_SAMPLE;
         RCMD_SAMPLE: if (!hard_reset_in_act) state_d = RCMD_APPLY;
         RCMD_APPLY:  state_d = RCMD_RUN;
         default:     state_d = RCMD_RUN;
      endcase
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= RCMD_RUN;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // -----------------------------------------------------------------------------
   // Sampling of straps and configuration word while hard reset is held
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_code_q <= 7'h00;
         pend_ext_q  <= 1'b0;
      end else if (clk_en && hard_reset_in_act) begin
         pend_code_q[2:0] <= straps_s;
         if (cfgsel_act && ctrl_q[`RCMD_CTRL_EXT_EN]) begin
            pend_code_q[6:3] <= upper_s;
            pend_ext_q       <= 1'b1;
         end else begin
            pend_code_q[6:3] <= 4'h0;
            pend_ext_q       <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Power-on reset arms the next apply; a bare hard reset does not
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_q <= 1'b1;
      end else if (clk_en) begin
         if (por_act) begin
            armed_q <= 1'b1;
         end else if (state_q == RCMD_APPLY) begin
            armed_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // Applied configuration, changed only at an armed apply step
   // -----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpm_mult_half     <= `RCMD_B0_CPM;
         core_mult_half    <= `RCMD_B0_CORE;
         cpm_mult_frac     <= 1'b0;
         core_mult_frac    <= 1'b0;
         applied_mode_code <= 7'h00;
         applied_mode_ext  <= 1'b0;
      end else if (clk_en && state_q == RCMD_APPLY && armed_q) begin
         cpm_mult_half     <= dec.cpm_half;
         core_mult_half    <= dec.core_half;
         cpm_mult_frac     <= dec.cpm_half[0];
         core_mult_frac    <= dec.core_half[0];
         applied_mode_code <= pend_code_q;
         applied_mode_ext  <= pend_ext_q;
      end
   end

   // -----------------------------------------------------------------------------
   // AXI4-Lite write path: address and data in either order
   // -----------------------------------------------------------------------------
   assign aw_hs     = s_axi_awvalid & s_axi_awready;
   assign w_hs      = s_axi_wvalid & s_axi_wready;
   assign wr_commit = aw_full_q & w_full_q & ~s_axi_bvalid;

   // Write channel holding registers and ready flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         aw_addr_q     <= 12'h000;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else if (clk_en) begin
         if (aw_hs) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_commit) begin
            aw_full_q <= 1'b0;
         end
         if (w_hs) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_commit) begin
            w_full_q <= 1'b0;
         end
         // Ready only while the holding slot is free and no response waits
         s_axi_awready <= ~(aw_full_q | aw_hs) & ~s_axi_bvalid & ~wr_commit;
         s_axi_wready  <= ~(w_full_q | w_hs) & ~s_axi_bvalid & ~wr_commit;
      end
   end

   // Write response and control register update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RCMD_RESP_OKAY;
         ctrl_q       <= `RCMD_CTRL_RESET;
      end else if (clk_en) begin
         if (wr_commit) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_addr_q)
               `RCMD_OFS_CTRL: begin
                  s_axi_bresp <= `RCMD_RESP_OKAY;
                  if (w_strb_q[0]) begin
                     ctrl_q <= w_data_q[7:0];
                  end
               end
               `RCMD_OFS_STATUS, `RCMD_OFS_FACTORS, `RCMD_OFS_PENDING: begin
                  s_axi_bresp <= `RCMD_RESP_OKAY;   // Read-only, write ignored
               end
               default: begin
                  s_axi_bresp <= `RCMD_RESP_SLVERR; // Unmapped address
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------------------
   // AXI4-Lite read path
   // -----------------------------------------------------------------------------
   assign ar_hs = s_axi_arvalid & s_axi_arready;

   // Read word mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_resp = `RCMD_RESP_OKAY;
      unique case (s_axi_araddr)
         `RCMD_OFS_CTRL: begin
            rd_word[7:0] = ctrl_q;
         end
         `RCMD_OFS_STATUS: begin
            rd_word[`RCMD_ST_CODE_LSB +: 7] = applied_mode_code;
            rd_word[`RCMD_ST_EXT]           = applied_mode_ext;
            rd_word[`RCMD_ST_UNSUP]         = dec.unsupported;
            rd_word[`RCMD_ST_ARMED]         = armed_q;
            rd_word[`RCMD_ST_HARD_RESET_IN]        = hard_reset_in_act;
         end
         `RCMD_OFS_FACTORS: begin
            rd_word[`RCMD_FA_CPM_LSB +: 5]  = cpm_mult_half;
            rd_word[`RCMD_FA_CPM_FRAC]      = cpm_mult_frac;
            rd_word[`RCMD_FA_CORE_LSB +: 5] = core_mult_half;
            rd_word[`RCMD_FA_CORE_FRAC]     = core_mult_frac;
         end
         `RCMD_OFS_PENDING: begin
            rd_word[`RCMD_ST_CODE_LSB +: 7] = pend_code_q;
            rd_word[`RCMD_ST_EXT]           = pend_ext_q;
         end
         default: begin
            rd_resp = `RCMD_RESP_SLVERR;
         end
      endcase
   end

   // Read channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RCMD_RESP_OKAY;
      end else if (clk_en) begin
         if (ar_hs) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_resp;
            s_axi_arready <= 1'b0;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else begin
            s_axi_arready <= ~s_axi_rvalid;
         end
      end
   end

endmodule
`default_nettype wire

// ### rcmd_top_assertions.sv
// Checks on the applied clock factors
`timescale 1ns/100ps
`default_nettype none
module rcmd_top_assertions (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       hard_reset_in_n,
   input  wire logic       power_on_reset_n,
   input  wire logic [2:0] clock_mode_straps,
   input  wire logic [3:0] extended_mode_upper_bits,
   input  wire logic [4:0] cpm_mult_half,
   input  wire logic       cpm_mult_frac,
   input  wire logic [4:0] core_mult_half,
   input  wire logic       core_mult_frac,
   input  wire logic [6:0] applied_mode_code,
   input  wire logic       applied_mode_ext
);
   logic [3:0] hr_cnt_q;  // Edges since the hard reset pin rose
   logic       armed_q;   // Power-on reset seen since last apply
   logic [2:0] strap_q;   // Straps seen in hard reset
   logic [3:0] upper_q;   // Upper bits seen in hard reset
   logic [6:0] ofs;       // Offset into the extended table
   logic [6:0] e_cpm;     // Expected extended comm factor
   logic [6:0] e_core;    // Expected extended core factor
   assign ofs = applied_mode_code - 7'h08;
   assign e_cpm = 7'h04 + 7'h02 * (ofs / 7'h05);
   assign e_core = 7'h08 + 7'h02 * (ofs % 7'h05);
   // Hard reset tracking
   always_ff @(posedge aclk) begin
      if (!aresetn) hr_cnt_q <= 4'hF;
      else if (!hard_reset_in_n) hr_cnt_q <= 4'h0;
      else if (hr_cnt_q != 4'hF) hr_cnt_q <= hr_cnt_q + 4'h1;
   end
   // Armed by power-on reset, spent by hard reset
   always_ff @(posedge aclk) begin
      if (!aresetn || !power_on_reset_n) armed_q <= 1'b1;
      else if (hr_cnt_q == 4'h8) armed_q <= 1'b0;
   end
   // Pin capture while hard reset is low
   always_ff @(posedge aclk) begin
      if (!hard_reset_in_n) begin
         strap_q <= clock_mode_straps;
         upper_q <= extended_mode_upper_bits;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   hold_out_a: assert property (
      $changed({cpm_mult_half, core_mult_half, applied_mode_code}) |-> hr_cnt_q inside {[4'h1:4'h7]})
      else $error("factors moved outside apply");
   apply_armed_a: assert property (
      $changed({cpm_mult_half, core_mult_half, applied_mode_code}) |-> armed_q)
      else $error("factors moved unarmed");
   cpm_frac_a: assert property (cpm_mult_frac == cpm_mult_half[0])
      else $error("comm frac wrong");
   core_frac_a: assert property (core_mult_frac == core_mult_half[0])
      else $error("core frac wrong");
   basic_low_a: assert property (
      !applied_mode_ext && !applied_mode_code[2] |->
      cpm_mult_half == (applied_mode_code[1] ? 5'h08 : 5'h06) &&
      core_mult_half == (applied_mode_code[0] ? 5'h0A : 5'h08))
      else $error("basic low decode");
   basic_high_a: assert property (
      !applied_mode_ext && applied_mode_code[2] |->
      cpm_mult_half == (applied_mode_code[1] ? 5'h05 : 5'h04) &&
      core_mult_half == (applied_mode_code[0] ? 5'h06 : 5'h05))
      else $error("basic high decode");
   ext_map_a: assert property (
      applied_mode_ext |-> ofs <= 7'h18 && {2'h0, cpm_mult_half} == e_cpm &&
      {2'h0, core_mult_half} == e_core)
      else $error("extended decode");
   strap_cap_a: assert property (
      $changed(applied_mode_code) |-> applied_mode_code[2:0] == strap_q)
      else $error("straps not sampled");
   ext_bits_a: assert property (
      $changed(applied_mode_code) && applied_mode_ext |-> applied_mode_code[6:3] == upper_q)
      else $error("upper bits not sampled");
   cover property (applied_mode_ext);
   cover property ($changed(applied_mode_code));
   cover property (cpm_mult_frac && core_mult_frac);
endmodule
`default_nettype wire

// ### rcmd_board.sv
// Board model: power-on reset, hard reset, straps and configuration word
`timescale 1ns/100ps
`default_nettype none
module rcmd_board (
   input  wire logic       aclk,
   output logic            hard_reset_in_n,
   output logic            power_on_reset_n,
   output logic            reset_config_select_n,
   output logic      [2:0] clock_mode_straps,
   output logic      [3:0] extended_mode_upper_bits
);
   initial begin
      hard_reset_in_n = 1'b1;
      power_on_reset_n = 1'b1;
      reset_config_select_n = 1'b1;
      clock_mode_straps = 3'h0;
      extended_mode_upper_bits = 4'h5;
   end
   // Power-on reset pulse
   task por();
      @(posedge aclk);
      power_on_reset_n <= 1'b0;
      repeat (3) @(posedge aclk);
      power_on_reset_n <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask
   // Hard reset, config word driven when selected
   task hard_reset(input logic [6:0] code, logic ext);
      @(posedge aclk);
      hard_reset_in_n <= 1'b0;
      clock_mode_straps <= code[2:0];
      reset_config_select_n <= ~ext;
      if (ext) extended_mode_upper_bits <= code[6:3];
      repeat (6) @(posedge aclk);
      hard_reset_in_n <= 1'b1;
      repeat (6) @(posedge aclk);
      reset_config_select_n <= 1'b1;
      extended_mode_upper_bits <= ~extended_mode_upper_bits; // Bus released
   endtask
endmodule
`default_nettype wire

// ### tb_rcmd_top.sv
// Testbench for the reset clock mode decoder
`timescale 1ns/100ps
`default_nettype none
`include "rcmd_cfg.svh"
module tb_rcmd_top;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
   logic hard_reset_in_n, power_on_reset_n, reset_config_select_n;
   logic [2:0] clock_mode_straps;
   logic [3:0] extended_mode_upper_bits;
   logic [4:0] cpm_mult_half, core_mult_half;
   logic cpm_mult_frac, core_mult_frac, applied_mode_ext;
   logic [6:0] applied_mode_code;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int errors = 0, checks_done = 0;
   // Basic factors in half units
   localparam logic [4:0] CPM_T [8] = '{5'h06, 5'h06, 5'h08, 5'h08, 5'h04, 5'h04, 5'h05, 5'h05};
   localparam logic [4:0] CORE_T [8] = '{5'h08, 5'h0A, 5'h08, 5'h0A, 5'h05, 5'h06, 5'h05, 5'h06};
   always #12.5 aclk = ~aclk;
   rcmd_board u_board (.aclk, .hard_reset_in_n, .power_on_reset_n, .reset_config_select_n,
      .clock_mode_straps, .extended_mode_upper_bits);
   rcmd_top u_dut (.aclk, .aresetn, .clk_en, .hard_reset_in_n, .power_on_reset_n,
      .reset_config_select_n, .clock_mode_straps, .extended_mode_upper_bits, .cpm_mult_half,
      .cpm_mult_frac, .core_mult_half, .core_mult_frac, .applied_mode_code, .applied_mode_ext,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // Verdict and end of run
   task end_sim(input int e);
      errors += e;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask
   // Bus write
   task wr(input logic [11:0] a, logic [31:0] d, logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) end_sim(1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   // Bus read
   task rd(input logic [11:0] a, logic [31:0] ed, logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) end_sim(1);
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // Applied code and factors
   task out_chk(input logic [6:0] c, logic x, logic [4:0] p, k);
      chk({24'h0, x, c}, {24'h0, applied_mode_ext, applied_mode_code});
      chk({20'h0, core_mult_frac, core_mult_half, cpm_mult_frac, cpm_mult_half},
         {20'h0, k[0], k, p[0], p});
      rd(`RCMD_OFS_FACTORS, {16'h0, k[0], 2'h0, k, p[0], 2'h0, p}, `RCMD_RESP_OKAY);
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      out_chk(7'h00, 1'b0, 5'h06, 5'h08);
      rd(`RCMD_OFS_CTRL, 32'h1, `RCMD_RESP_OKAY);
      rd(12'h010, 32'h0, `RCMD_RESP_SLVERR);
      wr(12'h010, 32'h0, `RCMD_RESP_SLVERR);
      wr(`RCMD_OFS_CTRL, 32'h1, `RCMD_RESP_OKAY);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         u_board.por();
         u_board.hard_reset(7'(c), 1'b0);
         out_chk(7'(c), 1'b0, CPM_T[c], CORE_T[c]);
      end
      $display("test basic modes done");
      u_board.por();
      u_board.hard_reset(7'h08, 1'b1);
      out_chk(7'h08, 1'b1, 5'h04, 5'h08);
      u_board.por();
      u_board.hard_reset(7'h20, 1'b1);
      out_chk(7'h20, 1'b1, 5'h0C, 5'h10);
      $display("test extended modes done");
      u_board.hard_reset(7'h7B, 1'b1);
      out_chk(7'h20, 1'b1, 5'h0C, 5'h10);
      rd(`RCMD_OFS_STATUS, 32'h320, `RCMD_RESP_OKAY);
      rd(`RCMD_OFS_PENDING, 32'h17B, `RCMD_RESP_OKAY);
      $display("test hard reset alone done");
      end_sim(0);
   end
endmodule
bind rcmd_top rcmd_top_assertions u_chk (.aclk, .aresetn, .hard_reset_in_n, .power_on_reset_n,
   .clock_mode_straps, .extended_mode_upper_bits, .cpm_mult_half, .cpm_mult_frac,
   .core_mult_half, .core_mult_frac, .applied_mode_code, .applied_mode_ext);
`default_nettype wire
